/* File: core/atp_pkg.sv */
// Constants and carrier types for the conversion trigger and pacer block
package atp_pkg;

    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ   = 40_000_000;
    localparam int unsigned BASE_CLK_HZ  = 10_000_000;
    localparam int unsigned BASE_DIV     = SYS_CLK_HZ / BASE_CLK_HZ;
    localparam int unsigned PRESC_W      = 2;
    localparam logic [1:0]  PRESC_LAST   = 2'(BASE_DIV - 1);
    localparam logic [1:0]  PRESC_RST    = 2'h0;

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W        = 16;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam int unsigned PACER_DIV_MIN = 2;

    // ------------------------------------------------------------------
    // Event input limits (0.1 Hz held as tenths of a hertz)
    // ------------------------------------------------------------------
    localparam int unsigned SW_EVT_MAX_HZ   = 10_000;
    localparam int unsigned FAST_EVT_MAX_HZ = 1_000;
    localparam int unsigned EVT_MIN_DHZ     = 1;
    localparam int unsigned SW_EVT_GAP      =
        (BASE_CLK_HZ + SW_EVT_MAX_HZ - 1) / SW_EVT_MAX_HZ;
    localparam int unsigned FAST_EVT_GAP    =
        (BASE_CLK_HZ + FAST_EVT_MAX_HZ - 1) / FAST_EVT_MAX_HZ;
    localparam int unsigned EVT_TIMEOUT     =
        (BASE_CLK_HZ / EVT_MIN_DHZ) * 10;
    localparam int unsigned PER_W           = 27;

    // ------------------------------------------------------------------
    // Pulse output limits, in base ticks per half period
    // ------------------------------------------------------------------
    localparam int unsigned PULSE_MIN_HZ    = 2;
    localparam int unsigned PULSE_MAX_HZ    = 10_000;
    localparam int unsigned PULSE_HALF_MIN  = BASE_CLK_HZ / (2 * PULSE_MAX_HZ);
    localparam int unsigned PULSE_HALF_MAX  = BASE_CLK_HZ / (2 * PULSE_MIN_HZ);
    localparam int unsigned HALF_W          = 22;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                pacer_en;
        logic [CNT_W-1:0]    pacer_div;
        logic                ext_trig_en;
        logic                fast_acquisition_mode;
        logic                pulse_en;
        logic [HALF_W-1:0]   pulse_half;
    } atp_cfg_t;

    typedef struct packed {
        logic [CNT_W-1:0]    event_count;
        logic [PER_W-1:0]    event_period;
        logic                period_valid;
        logic                pacer_out;
        logic                pulse_out;
    } atp_status_t;

endpackage

/* File: core/atp_trigger_pacer.sv */
// Conversion start, event counter, pacer timer and pulse output logic
//
// Operation
// - Two independent 16-bit counters both step on a shared 10 MHz base tick.
// - The event counter increments once per rising edge on event_input, dropping edges closer than the mode's rate-limit gap.
// - The 16-bit pacer timer starts a conversion on each rising output edge.
// - While the trigger inhibit input is high external triggers are ignored.
// - With external triggering on, a rising trigger edge starts a conversion.
// - Events count up to 10 kHz polled, 1 kHz in fast mode, down to 0.1 Hz.
// - The pulse output is a square wave settable between 2 Hz and 10 kHz.
`timescale 1ns/1ps
module atp_trigger_pacer import atp_pkg::*; #(
    parameter int unsigned SW_GAP   = SW_EVT_GAP,
    parameter int unsigned FAST_GAP = FAST_EVT_GAP,
    parameter int unsigned TIMEOUT  = EVT_TIMEOUT,
    parameter int unsigned HALF_MAX = PULSE_HALF_MAX
) (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Configuration
    input  wire atp_cfg_t    i_cfg,
    // External pins
    input  wire logic        i_event_input,
    input  wire logic        i_external_conversion_trigger,
    input  wire logic        i_trigger_inhibit,
    // Converter side and status
    output logic             o_conv_start,
    output logic             o_pulse_out,
    output atp_status_t      o_status
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic int unsigned clamp_u(input int unsigned v,
                                            input int unsigned lo,
                                            input int unsigned hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Base tick prescaler
    // ------------------------------------------------------------------
    logic [PRESC_W-1:0] presc_reg;
    logic               base_tick;

    assign base_tick = (presc_reg == PRESC_LAST);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            presc_reg <= PRESC_RST;
        end else begin
            presc_reg <= base_tick ? PRESC_RST : presc_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Event counter with rate limit and period capture
    // ------------------------------------------------------------------
    logic              evt_prev_reg;
    logic              evt_pend_reg;
    logic              evt_rise;
    logic              evt_take;
    logic              evt_counted;
    logic              first_seen_reg;
    logic [CNT_W-1:0]  evt_count_reg;
    logic [PER_W-1:0]  elapsed_reg;
    logic [PER_W-1:0]  period_reg;
    logic              period_valid_reg;
    logic [PER_W-1:0]  gap_m1;
    logic              elapsed_sat;

    assign evt_rise    = i_event_input & ~evt_prev_reg;
    assign evt_take    = base_tick & (evt_pend_reg | evt_rise);
    assign gap_m1      = i_cfg.fast_acquisition_mode ?
                         PER_W'(FAST_GAP - 1) : PER_W'(SW_GAP - 1);
    assign elapsed_sat = (elapsed_reg >= PER_W'(TIMEOUT));
    assign evt_counted = evt_take & (~first_seen_reg | elapsed_reg >= gap_m1);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            evt_prev_reg <= 1'b0;
            evt_pend_reg <= 1'b0;
        end else begin
            evt_prev_reg <= i_event_input;
            // A new edge outside the tick cycle stays pending for the next tick
            if (evt_rise & ~base_tick) begin
                evt_pend_reg <= 1'b1;
            end else if (base_tick) begin
                evt_pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            evt_count_reg    <= CNT_RST;
            first_seen_reg   <= 1'b0;
            elapsed_reg      <= '0;
            period_reg       <= '0;
            period_valid_reg <= 1'b0;
        end else if (evt_counted) begin
            evt_count_reg    <= evt_count_reg + CNT_W'(1);
            first_seen_reg   <= 1'b1;
            elapsed_reg      <= '0;
            period_reg       <= elapsed_reg + PER_W'(1);
            period_valid_reg <= first_seen_reg & ~elapsed_sat;
        end else if (base_tick & ~elapsed_sat) begin
            elapsed_reg      <= elapsed_reg + PER_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Pacer timer
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] pacer_cnt_reg;
    logic [CNT_W-1:0] pacer_div_eff;
    logic             pacer_out_reg;
    logic             pacer_prev_reg;
    logic             pacer_tc;
    logic             pacer_rise;

    assign pacer_div_eff = CNT_W'(clamp_u(32'(i_cfg.pacer_div),
                                          PACER_DIV_MIN, 32'hFFFF));
    assign pacer_tc      = base_tick & (pacer_cnt_reg <= CNT_W'(1));
    assign pacer_rise    = pacer_out_reg & ~pacer_prev_reg;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst | ~i_cfg.pacer_en) begin
            pacer_cnt_reg <= pacer_div_eff;
            pacer_out_reg <= 1'b0;
        end else if (base_tick) begin
            pacer_out_reg <= pacer_tc;
            pacer_cnt_reg <= pacer_tc ? pacer_div_eff :
                             pacer_cnt_reg - CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Conversion start
    // ------------------------------------------------------------------
    logic ext_prev_reg;
    logic ext_rise;
    logic conv_reg;

    assign ext_rise = i_external_conversion_trigger & ~ext_prev_reg &
                      i_cfg.ext_trig_en & ~i_trigger_inhibit;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ext_prev_reg   <= 1'b0;
            pacer_prev_reg <= 1'b0;
            conv_reg       <= 1'b0;
        end else begin
            ext_prev_reg   <= i_external_conversion_trigger;
            pacer_prev_reg <= pacer_out_reg;
            conv_reg       <= pacer_rise | ext_rise;
        end
    end

    assign o_conv_start = conv_reg;

    // ------------------------------------------------------------------
    // Pulse output generator
    // ------------------------------------------------------------------
    logic [HALF_W-1:0] pulse_cnt_reg;
    logic [HALF_W-1:0] pulse_half_eff;
    logic              pulse_reg;

    assign pulse_half_eff = HALF_W'(clamp_u(32'(i_cfg.pulse_half),
                                            PULSE_HALF_MIN, HALF_MAX));

    always_ff @(posedge i_sys_clk) begin
        if (i_rst | ~i_cfg.pulse_en) begin
            pulse_cnt_reg <= '0;
            pulse_reg     <= 1'b0;
        end else if (base_tick) begin
            if (pulse_cnt_reg >= pulse_half_eff - HALF_W'(1)) begin
                pulse_cnt_reg <= '0;
                pulse_reg     <= ~pulse_reg;
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg + HALF_W'(1);
            end
        end
    end

    assign o_pulse_out = pulse_reg;

    always_comb begin
        o_status.event_count  = evt_count_reg;
        o_status.event_period = period_reg;
        o_status.period_valid = period_valid_reg;
        o_status.pacer_out    = pacer_out_reg;
        o_status.pulse_out    = pulse_reg;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic        pulse_prev_reg;
    logic [31:0] hold_cnt_reg;

    // Clocks since the last toggle, counted only once a toggle was seen
    always_ff @(posedge i_sys_clk) begin
        if (i_rst | ~i_cfg.pulse_en) begin
            pulse_prev_reg <= 1'b0;
            hold_cnt_reg   <= '0;
        end else begin
            pulse_prev_reg <= pulse_reg;
            if (pulse_reg != pulse_prev_reg) begin
                hold_cnt_reg <= 32'h1;
            end else if (hold_cnt_reg != 32'h0 &&
                         hold_cnt_reg != 32'hFFFFFFFF) begin
                hold_cnt_reg <= hold_cnt_reg + 32'h1;
            end
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_base_tick_spacing: assert property (
        base_tick |=> !base_tick [*3] ##1 base_tick)
        else $error("base tick not every fourth clock");
    a_event_count_step: assert property (
        evt_counted |=> evt_count_reg == $past(evt_count_reg) + 16'h0001)
        else $error("event count did not step by one");
    a_event_count_hold: assert property (
        !evt_counted |=> $stable(evt_count_reg))
        else $error("event count moved without an event");
    a_pacer_conv_start: assert property (
        $rose(pacer_out_reg) |=> o_conv_start)
        else $error("pacer edge did not start conversion");
    a_inhibit_blocks_ext: assert property (
        (i_trigger_inhibit && !pacer_rise) |=> !o_conv_start)
        else $error("conversion started while inhibited");
    a_ext_edge_start: assert property (
        ($rose(i_external_conversion_trigger) && i_cfg.ext_trig_en &&
         !i_trigger_inhibit) |=> o_conv_start)
        else $error("external edge did not start conversion");
    a_fast_rate_limit: assert property (
        (evt_counted && first_seen_reg && i_cfg.fast_acquisition_mode)
        |=> period_reg >= PER_W'(FAST_GAP))
        else $error("fast mode event accepted too soon");
    a_pulse_half_min: assert property (
        ((pulse_reg != pulse_prev_reg) && hold_cnt_reg != 32'h0)
        |-> hold_cnt_reg >= 32'(BASE_DIV * PULSE_HALF_MIN))
        else $error("pulse half period shorter than allowed");
    a_pulse_half_max: assert property (
        ((pulse_reg != pulse_prev_reg) && hold_cnt_reg != 32'h0)
        |-> hold_cnt_reg <= 32'(BASE_DIV * HALF_MAX))
        else $error("pulse half period longer than allowed");
    a_pacer_reload: assert property (
        (pacer_tc && i_cfg.pacer_en) |=> pacer_cnt_reg == $past(pacer_div_eff))
        else $error("pacer did not reload divisor");

    c_pacer_conv: cover property ($rose(pacer_out_reg) ##1 o_conv_start);
    c_ext_conv: cover property (ext_rise ##1 o_conv_start);
    c_event_counted: cover property (evt_counted && first_seen_reg);
    c_pulse_toggle: cover property ($rose(pulse_reg));

endmodule

/* File: verif/adc_trigger_pacer_test.sv */
// Self-checking bench for the trigger, pacer, event and pulse logic
`timescale 1ns/1ps
module adc_trigger_pacer_test import atp_pkg::*; ;
    localparam int unsigned SWG = 10;
    localparam int unsigned FAG = 20;
    localparam int unsigned HMX = 600;
    localparam int unsigned TOUT = 200;
    localparam int          LIM = 20000;
    logic        i_sys_clk = 1'b0;
    logic        i_rst     = 1'b1;
    atp_cfg_t    cfg       = '0;
    logic        ev        = 1'b0;
    logic        trg       = 1'b0;
    logic        inh       = 1'b0;
    logic        conv;
    logic        pout;
    atp_status_t st;
    logic [15:0] conv_cnt;
    logic [31:0] conv_gap;
    int          fails     = 0;
    int          checks    = 0;
    int          ev_first  = 1;
    int          ev_since  = 0;
    int          ev_cnt    = 0;
    int          ev_per    = 0;

    atp_trigger_pacer #(.SW_GAP(SWG), .FAST_GAP(FAG), .TIMEOUT(TOUT),
        .HALF_MAX(HMX)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg(cfg),
        .i_event_input(ev), .i_external_conversion_trigger(trg),
        .i_trigger_inhibit(inh), .o_conv_start(conv),
        .o_pulse_out(pout), .o_status(st));
    atp_conv_model conv_model (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_conv_start(conv),
        .o_conv_count(conv_cnt), .o_conv_gap(conv_gap));

    initial begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        fails++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1);
        end_sim();
    endtask

    task automatic wait_conv(input int n);
        int target;
        int i;
        target = int'(conv_cnt) + n;
        for (i = 0; i < LIM && int'(conv_cnt) != target; i++) cyc(1);
        if (i >= LIM) hang();
    endtask

    task automatic wait_tog(output int n);
        logic prev;
        prev = pout;
        n = 0;
        while (pout === prev && n < LIM) begin
            cyc(1);
            n++;
        end
        if (n >= LIM) hang();
    endtask

    // One event edge in the given mode, then k base ticks to the next one
    task automatic ev_step(input int k, input logic fast);
        int gap;
        gap = fast ? FAG : SWG;
        cfg.fast_acquisition_mode <= fast;
        ev <= 1'b1;
        cyc(2);
        ev <= 1'b0;
        cyc(10);
        if (ev_first == 1 || ev_since >= gap) begin
            ev_cnt++;
            ev_per = ev_since;
            cmp(st.period_valid, ev_first == 0 && ev_since <= TOUT);
            if (ev_first == 0 && ev_since <= TOUT) begin
                cmp(st.event_period, ev_per);
            end
            ev_since = 0;
            ev_first = 0;
        end
        cmp(st.event_count, ev_cnt & 16'hFFFF);
        ev_since += k;
        cyc(4 * k - 12);
    endtask

    initial begin
        int d;
        int n;
        int dv[3];
        int tv[4][3];
        int hv[3][2];
        d = $urandom(19202);
        dv = '{0, 2, 3 + $urandom % 40};
        tv = '{'{1, 0, 1}, '{1, 1, 0}, '{0, 0, 0}, '{1, 0, 1}};
        hv = '{'{100, 500}, '{550, 550}, '{700, HMX}};
        cyc(20);
        i_rst <= 1'b0;
        cyc(2);
        foreach (dv[i]) begin
            cfg.pacer_div <= 16'(dv[i]);
            cfg.pacer_en  <= 1'b1;
            wait_conv(3);
            cmp(conv_gap, 4 * (dv[i] < 2 ? 2 : dv[i]));
            cfg.pacer_en <= 1'b0;
            cyc(12);
        end
        $display("pacer test done");
        foreach (tv[i]) begin
            n = int'(conv_cnt);
            cfg.ext_trig_en <= tv[i][0];
            inh             <= tv[i][1];
            cyc(2);
            trg <= 1'b1;
            cyc(4);
            trg <= 1'b0;
            cyc(4);
            cmp(int'(conv_cnt) - n, tv[i][2]);
        end
        inh <= 1'b0;
        $display("trigger test done");
        foreach (dv[i]) ev_step(15, 1'b0);
        ev_step(3, 1'b0);
        ev_step(12, 1'b0);
        ev_step(15, 1'b1);
        ev_step(25, 1'b1);
        ev_step(25, 1'b1);
        ev_step(3 + $urandom % 20, 1'b0);
        ev_step(10, 1'b0);
        ev_step(TOUT + 10, 1'b0);
        ev_step(10, 1'b0);
        $display("event test done");
        foreach (hv[i]) begin
            cfg.pulse_half <= 22'(hv[i][0]);
            cfg.pulse_en   <= 1'b1;
            wait_tog(n);
            wait_tog(n);
            cmp(n, 4 * hv[i][1]);
            cmp(st.pulse_out, pout);
            cfg.pulse_en <= 1'b0;
            cyc(12);
            cmp(pout, 1'b0);
        end
        $display("pulse test done");
        end_sim();
    end
endmodule

/* File: verif/atp_conv_model.sv */
// Converter model that takes conversion starts and logs their spacing
`timescale 1ns/1ps
module atp_conv_model (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Start request from the block
    input  wire logic        i_conv_start,
    // Observed conversions
    output logic [15:0]      o_conv_count,
    output logic [31:0]      o_conv_gap
);
    logic [31:0] since_reg;

    // One conversion per start pulse, spacing in system clocks
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            since_reg    <= 32'h0;
            o_conv_count <= 16'h0;
            o_conv_gap   <= 32'h0;
        end else begin
            since_reg <= since_reg + 32'h1;
            if (i_conv_start) begin
                o_conv_count <= o_conv_count + 16'h1;
                o_conv_gap   <= since_reg + 32'h1;
                since_reg    <= 32'h0;
            end
        end
    end
endmodule
